//--- debug_port_pkg.sv
// Shared constants for the JTAG debug communication port
package debug_port_pkg;
  localparam int          IR_W          = 4;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;
  localparam logic [3:0]  OP_PROG       = 4'h5;
  localparam logic [3:0]  OP_COMM       = 4'h8;
  localparam logic [3:0]  OP_INSTR      = 4'h9;
  localparam logic [3:0]  OP_BP         = 4'ha;
  localparam logic [3:0]  OP_CTRL       = 4'hb;
  localparam logic [3:0]  OP_BYPASS     = 4'hf;
  localparam logic [3:0]  OP_PRIV_MASK  = 4'hc;
  localparam logic [3:0]  OP_PRIV_BASE  = 4'h8;

  localparam int          DR_MAX        = 18;
  localparam logic [4:0]  LEN_COMM      = 5'h09;
  localparam logic [4:0]  LEN_INSTR     = 5'h10;
  localparam logic [4:0]  LEN_BP        = 5'h12;
  localparam logic [4:0]  LEN_CTRL      = 5'h06;
  localparam logic [4:0]  LEN_PROG      = 5'h0c;
  localparam logic [4:0]  LEN_BYPASS    = 5'h01;

  localparam int          ADDR_W        = 16;
  localparam int          INSTR_W       = 16;
  localparam int          BP_SLOTS      = 4;

  // Control register: {mode[2:0], flow_break, step_break, access_enable}
  localparam int          CTRL_ACCESS   = 0;
  localparam int          CTRL_STEP     = 1;
  localparam int          CTRL_FLOW     = 2;
  localparam int          CTRL_MODE_LO  = 3;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;
  localparam logic [7:0]  COMM_RESET    = 8'h00;

  // Programming word: {erase, target[1:0], verify, data[7:0]}
  localparam int          PROG_ERASE    = 11;
  localparam int          PROG_TGT_LO   = 9;
  localparam int          PROG_VERIFY   = 8;
  localparam logic [1:0]  TGT_FLASH     = 2'h0;
  localparam logic [1:0]  TGT_EEPROM    = 2'h1;
  localparam logic [1:0]  TGT_FUSE      = 2'h2;
  localparam logic [1:0]  TGT_LOCK      = 2'h3;
  localparam int          FUSE_DEBUG_BIT = 7;
  localparam int          LOCK_ONE_BIT  = 0;
  localparam int          LOCK_TWO_BIT  = 1;

  typedef enum logic [2:0] {
    MODE_4P, MODE_3P1D, MODE_2P2D, MODE_2P_RANGE_P, MODE_2P_RANGE_D
  } bp_mode_t;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;
endpackage

//--- instr_fifo.sv
// Instruction word FIFO between debugger side and CPU scan side
`timescale 1ns/1ps
`default_nettype none
module instr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

//--- break_unit.sv
// Breakpoint comparators, flow-change and single-step break
`timescale 1ns/1ps
`default_nettype none
module break_unit
  import debug_port_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    enable,
  input  wire bp_mode_t                mode,
  input  wire logic                    flow_en,
  input  wire logic                    step_en,
  input  wire logic [BP_SLOTS*AW-1:0]  slot_addr,
  input  wire logic [BP_SLOTS-1:0]     slot_arm,
  input  wire logic                    pc_valid,
  input  wire logic [AW-1:0]           pc,
  input  wire logic                    flow_change,
  input  wire logic                    data_valid,
  input  wire logic [AW-1:0]           data_addr,
  output logic                         break_req
);
  logic [BP_SLOTS-1:0] hit;
  logic [AW-1:0]       range_base;
  logic [AW-1:0]       range_mask;
  logic                range_hit_p;
  logic                range_hit_d;

  assign range_base  = slot_addr[2*AW +: AW];
  assign range_mask  = slot_addr[3*AW +: AW];
  assign range_hit_p = pc_valid && ((pc & range_mask) == (range_base & range_mask));
  assign range_hit_d = data_valid && ((data_addr & range_mask) == (range_base & range_mask));

  // Slots 0,1 always program memory; 2,3 follow the mode
  for (genvar i = 0; i < BP_SLOTS; i++) begin : g_slot
    logic is_data;
    logic pc_hit;
    logic dm_hit;
    assign is_data = ((i == 3) && (mode == MODE_3P1D || mode == MODE_2P2D)) ||
                     ((i == 2) && (mode == MODE_2P2D));
    assign pc_hit  = pc_valid && (pc == slot_addr[i*AW +: AW]);
    assign dm_hit  = data_valid && (data_addr == slot_addr[i*AW +: AW]);
    // One driver per bit; slot 3 is the mask in range modes
    assign hit[i] = slot_arm[i] &&
                    (((i >= 2) && (mode == MODE_2P_RANGE_P || mode == MODE_2P_RANGE_D)) ?
                     ((i == 2) && (mode == MODE_2P_RANGE_P ? range_hit_p : range_hit_d)) :
                     (is_data ? dm_hit : pc_hit));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      break_req <= 1'b0;
    end else begin
      break_req <= enable && ((|hit) || (flow_en && flow_change) || (step_en && pc_valid));
    end
  end

  AST_RANGE_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && slot_arm[2] && mode == MODE_2P_RANGE_P && range_hit_p) |=> break_req)
    else $error("range breakpoint hit did not break");
  AST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && step_en && pc_valid) |=> break_req)
    else $error("single step did not break");
endmodule
`default_nettype wire

//--- jtag_debug_comm_port.sv
// Debug port: sampled TAP, private debug instructions, communication register
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Debugger feeds CPU instructions through scan path
// - Flow, step breaks plus four breakpoint slots
// - Slots split as 4P, 3P+1D or 2P+2D
// - Two program breakpoints plus one masked range
// - TAP stays off without its fuse
// - TAP also needs disable bit cleared
// - Debug needs fuse and no lock bit
// - Codes 8 to B are debug instructions
// - CPU write stores byte, sets dirty flag
// - CPU read returns dirty flag in MSB
// - Shared address reaches debug byte when enabled
// - Only TCK, TMS, TDI, TDO are used
// - Program and verify flash, EEPROM, fuses, locks
// - Lock bit 0 or 1 set refuses debug fuse until erase
module jtag_debug_comm_port
  import debug_port_pkg::*;
#(
  parameter int LOCK_W = 6,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  wire logic               tap_enable_fuse,
  input  wire logic               debug_enable_fuse,
  input  wire logic               tap_disable_bit,
  input  wire logic [LOCK_W-1:0]  lock_bits,
  input  wire logic               cpu_io_sel,
  input  wire logic               cpu_io_wr,
  input  wire logic               cpu_io_rd,
  input  wire logic [7:0]         cpu_io_wdata,
  output logic      [7:0]         cpu_io_rdata,
  output logic                    shared_io_wr,
  output logic                    shared_io_rd,
  input  wire logic [7:0]         shared_io_rdata,
  output logic                    cpu_instr_valid,
  input  wire logic               cpu_instr_ready,
  output logic      [INSTR_W-1:0] cpu_instr,
  input  wire logic               pc_valid,
  input  wire logic [ADDR_W-1:0]  pc,
  input  wire logic               flow_change,
  input  wire logic               data_valid,
  input  wire logic [ADDR_W-1:0]  data_addr,
  output logic                    cpu_break,
  output logic                    prog_req,
  output logic                    prog_erase,
  output logic      [1:0]         prog_target,
  output logic                    prog_verify,
  output logic      [7:0]         prog_data,
  output logic                    prog_refused
);
  logic                 tck_s1, tck_s2, tck_s3;
  logic                 tms_s1, tms_s2;
  logic                 tdi_s1, tdi_s2;
  logic                 tck_rise, tck_fall;
  logic                 tap_on;
  logic                 debug_ok;
  tap_state_t           state, next_state;
  logic [IR_W-1:0]      ir_sh;
  logic [IR_W-1:0]      ir;
  logic [IR_W-1:0]      ir_eff;
  logic [DR_MAX-1:0]    dr;
  logic [DR_MAX-1:0]    next_dr;
  logic [DR_MAX-1:0]    cap_val;
  logic [4:0]           dr_len;
  logic [7:0]           comm_byte;
  logic                 debug_reg_dirty_flag;
  logic                 dbg_clear;
  logic                 dbg_hit;
  logic [5:0]           ctrl;
  logic [BP_SLOTS*ADDR_W-1:0] slot_addr;
  logic [BP_SLOTS-1:0]  slot_arm;
  logic                 erased;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 upd_dr;
  logic                 fuse_locked_write;

  // Link pins sampled into clk domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2} <= 2'h3;
      {tdi_s1, tdi_s2} <= 2'h0;
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
    end
  end
  assign tck_rise = tck_s2 && !tck_s3;
  assign tck_fall = !tck_s2 && tck_s3;

  assign tap_on   = tap_enable_fuse && !tap_disable_bit;
  assign debug_ok = debug_enable_fuse && !(|lock_bits);
  // Private codes fall back to bypass when debug is locked out
  assign ir_eff   = ((ir & OP_PRIV_MASK) == OP_PRIV_BASE && !debug_ok) ? OP_BYPASS : ir;

  always_comb begin
    next_state = state;
    case (state)
      TLR:     next_state = tms_s2 ? TLR : RTI;
      RTI:     next_state = tms_s2 ? SEL_DR : RTI;
      SEL_DR:  next_state = tms_s2 ? SEL_IR : CAP_DR;
      CAP_DR:  next_state = tms_s2 ? EX1_DR : SH_DR;
      SH_DR:   next_state = tms_s2 ? EX1_DR : SH_DR;
      EX1_DR:  next_state = tms_s2 ? UPD_DR : PA_DR;
      PA_DR:   next_state = tms_s2 ? EX2_DR : PA_DR;
      EX2_DR:  next_state = tms_s2 ? UPD_DR : SH_DR;
      UPD_DR:  next_state = tms_s2 ? SEL_DR : RTI;
      SEL_IR:  next_state = tms_s2 ? TLR : CAP_IR;
      CAP_IR:  next_state = tms_s2 ? EX1_IR : SH_IR;
      SH_IR:   next_state = tms_s2 ? EX1_IR : SH_IR;
      EX1_IR:  next_state = tms_s2 ? UPD_IR : PA_IR;
      PA_IR:   next_state = tms_s2 ? EX2_IR : PA_IR;
      EX2_IR:  next_state = tms_s2 ? UPD_IR : SH_IR;
      UPD_IR:  next_state = tms_s2 ? SEL_DR : RTI;
      default: next_state = TLR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TLR;
    end else if (!tap_on) begin
      state <= TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // Instruction register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh <= IR_CAPTURE;
      ir    <= OP_BYPASS;
    end else if (!tap_on || state == TLR) begin
      ir    <= OP_BYPASS;
      ir_sh <= IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == CAP_IR) begin
        ir_sh <= IR_CAPTURE;
      end else if (state == SH_IR) begin
        ir_sh <= {tdi_s2, ir_sh[IR_W-1:1]};
      end else if (state == UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // Data register length and capture value per instruction
  always_comb begin
    dr_len  = LEN_BYPASS;
    cap_val = '0;
    case (ir_eff)
      OP_COMM: begin
        dr_len  = LEN_COMM;
        cap_val = DR_MAX'({debug_reg_dirty_flag, comm_byte});
      end
      OP_INSTR: begin
        dr_len  = LEN_INSTR;
        cap_val = DR_MAX'(fifo_in_ready);
      end
      OP_BP:   dr_len = LEN_BP;
      OP_CTRL: begin
        dr_len  = LEN_CTRL;
        cap_val = DR_MAX'(ctrl);
      end
      OP_PROG: begin
        dr_len  = LEN_PROG;
        cap_val = DR_MAX'({erased, prog_refused});
      end
      default: dr_len = LEN_BYPASS;
    endcase
  end

  // Shift enters at the top of the selected length
  always_comb begin
    next_dr = '0;
    for (int i = 0; i < DR_MAX; i++) begin
      if (5'(i) == dr_len - 5'h01) begin
        next_dr[i] = tdi_s2;
      end else if (5'(i) < dr_len - 5'h01) begin
        next_dr[i] = dr[i+1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dr <= '0;
    end else if (tck_rise && state == CAP_DR) begin
      dr <= cap_val;
    end else if (tck_rise && state == SH_DR) begin
      dr <= next_dr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (state == SH_IR) ? ir_sh[0] : dr[0];
      tdo_oe <= tap_on && (state == SH_IR || state == SH_DR);
    end else if (!tap_on) begin
      tdo_oe <= 1'b0;
    end
  end

  assign upd_dr = tck_rise && tap_on && state == UPD_DR;

  // Debugger-side control, breakpoint slots
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= CTRL_RESET;
      slot_addr <= '0;
      slot_arm  <= '0;
    end else if (!debug_ok) begin
      ctrl     <= CTRL_RESET;
      slot_arm <= '0;
    end else if (upd_dr && ir_eff == OP_CTRL) begin
      ctrl <= dr[5:0];
    end else if (upd_dr && ir_eff == OP_BP) begin
      slot_addr[dr[17:16]*ADDR_W +: ADDR_W] <= dr[15:0];
      slot_arm[dr[17:16]] <= 1'b1;
    end
  end

  // Instruction words into the CPU scan path
  assign fifo_in_valid = upd_dr && ir_eff == OP_INSTR;
  instr_fifo #(
    .WIDTH (INSTR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (dr[INSTR_W-1:0]),
    .out_valid (cpu_instr_valid),
    .out_ready (cpu_instr_ready),
    .out_data  (cpu_instr)
  );

  break_unit #(
    .AW (ADDR_W)
  ) u_break (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (debug_ok),
    .mode        (bp_mode_t'(ctrl[CTRL_MODE_LO +: 3])),
    .flow_en     (ctrl[CTRL_FLOW]),
    .step_en     (ctrl[CTRL_STEP]),
    .slot_addr   (slot_addr),
    .slot_arm    (slot_arm),
    .pc_valid    (pc_valid),
    .pc          (pc),
    .flow_change (flow_change),
    .data_valid  (data_valid),
    .data_addr   (data_addr),
    .break_req   (cpu_break)
  );

  // CPU side of the communication register
  assign dbg_hit      = cpu_io_sel && debug_enable_fuse && ctrl[CTRL_ACCESS];
  assign shared_io_wr = cpu_io_sel && cpu_io_wr && !dbg_hit;
  assign shared_io_rd = cpu_io_sel && cpu_io_rd && !dbg_hit;
  assign dbg_clear    = upd_dr && ir_eff == OP_COMM;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_byte <= COMM_RESET;
    end else if (dbg_hit && cpu_io_wr) begin
      comm_byte <= cpu_io_wdata;
    end
  end

  // CPU write wins over a simultaneous debugger clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_reg_dirty_flag <= 1'b0;
    end else if (dbg_hit && cpu_io_wr) begin
      debug_reg_dirty_flag <= 1'b1;
    end else if (dbg_clear) begin
      debug_reg_dirty_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_io_rdata <= 8'h00;
    end else if (cpu_io_sel && cpu_io_rd) begin
      cpu_io_rdata <= dbg_hit ? {debug_reg_dirty_flag, comm_byte[6:0]} : shared_io_rdata;
    end
  end

  // Programming requests
  assign fuse_locked_write = dr[PROG_TGT_LO +: 2] == TGT_FUSE && !dr[PROG_VERIFY] && dr[FUSE_DEBUG_BIT] &&
                             (lock_bits[LOCK_ONE_BIT] || lock_bits[LOCK_TWO_BIT]) && !erased;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_req     <= 1'b0;
      prog_erase   <= 1'b0;
      prog_target  <= TGT_FLASH;
      prog_verify  <= 1'b0;
      prog_data    <= 8'h00;
      prog_refused <= 1'b0;
    end else begin
      prog_req <= 1'b0;
      if (upd_dr && ir_eff == OP_PROG) begin
        prog_refused <= fuse_locked_write;
        prog_req     <= !fuse_locked_write;
        prog_erase   <= dr[PROG_ERASE];
        prog_target  <= dr[PROG_TGT_LO +: 2];
        prog_verify  <= dr[PROG_VERIFY];
        prog_data    <= dr[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erased <= 1'b0;
    end else if (upd_dr && ir_eff == OP_PROG && dr[PROG_ERASE]) begin
      erased <= 1'b1;
    end
  end

  sequence s_cpu_write;
    dbg_hit && cpu_io_wr;
  endsequence
  sequence s_dbg_readout;
    upd_dr && ir_eff == OP_COMM && !(dbg_hit && cpu_io_wr);
  endsequence

  AST_TAP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (!tap_enable_fuse) |=> (state == TLR && !tdo_oe))
    else $error("TAP active without its fuse");
  AST_TAP_JTD: assert property (@(posedge clk) disable iff (!rst_n)
    tap_disable_bit |=> state == TLR)
    else $error("TAP active with disable bit set");
  AST_LOCK_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (|lock_bits) |=> (ctrl == CTRL_RESET && slot_arm == '0) ##1 !cpu_break)
    else $error("debug active while locked");
  AST_PRIV_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
    (!debug_ok && (ir & OP_PRIV_MASK) == OP_PRIV_BASE) |-> dr_len == LEN_BYPASS)
    else $error("private instruction reachable while locked");
  AST_WRITE_DIRTY: assert property (@(posedge clk) disable iff (!rst_n)
    s_cpu_write |=> (debug_reg_dirty_flag && comm_byte == $past(cpu_io_wdata)))
    else $error("cpu write did not store byte and set dirty");
  AST_READ_FORMAT: assert property (@(posedge clk) disable iff (!rst_n)
    (dbg_hit && cpu_io_rd) |=> cpu_io_rdata == {$past(debug_reg_dirty_flag), $past(comm_byte[6:0])})
    else $error("comm read format wrong");
  AST_DBG_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    s_dbg_readout |=> !debug_reg_dirty_flag)
    else $error("debugger readout did not clear dirty");
  AST_READ_NO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (debug_reg_dirty_flag && !dbg_clear) |=> debug_reg_dirty_flag)
    else $error("dirty flag dropped without debugger clear");
  AST_SHARED_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_io_sel && cpu_io_wr && !debug_enable_fuse) |-> (shared_io_wr ##1 $stable(comm_byte)))
    else $error("shared address routed to debug byte without fuse");
  AST_FUSE_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
    (upd_dr && ir_eff == OP_PROG && fuse_locked_write) |=> (prog_refused && !prog_req))
    else $error("locked debug fuse write not refused");
endmodule
`default_nettype wire

//--- jtag_host_model.sv
// Behavioural JTAG debugger driving TCK, TMS, TDI and sampling TDO
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One TCK period, TDO sampled just before the rise
  task automatic bit1(input logic m, input logic d, output logic q, output logic oe);
    tms = m;
    tdi = d;
    #62.5;
    q = tdo;
    oe = tdo_oe;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic q, oe;
    for (int i = 0; i < 5; i++) bit1(1'b1, 1'b0, q, oe);
    bit1(1'b0, 1'b0, q, oe);
  endtask
  // From idle: capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout, output logic oe_any);
    logic q, oe;
    dout = '0;
    oe_any = 1'b0;
    bit1(1'b1, 1'b0, q, oe);
    if (ir) bit1(1'b1, 1'b0, q, oe);
    bit1(1'b0, 1'b0, q, oe);
    bit1(1'b0, 1'b0, q, oe);
    for (int i = 0; i < n; i++) begin
      bit1(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_any |= oe;
    end
    // Update of a comm scan clears the dirty flag after the byte was read
    bit1(1'b1, 1'b0, q, oe);
    bit1(1'b0, 1'b0, q, oe);
    tdi = ~din[n-1];
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the debug communication port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import debug_port_pkg::*;
  logic clk, rst_n, tck, tms, tdi, tdo, tdo_oe;
  logic tap_enable_fuse, debug_enable_fuse, tap_disable_bit;
  logic [5:0] lock_bits;
  logic cpu_io_sel, cpu_io_wr, cpu_io_rd, shared_io_wr, shared_io_rd;
  logic [7:0] cpu_io_wdata, cpu_io_rdata, shared_io_rdata, prog_data;
  logic cpu_instr_valid, cpu_instr_ready, pc_valid, flow_change, data_valid;
  logic [15:0] cpu_instr, pc, data_addr;
  logic cpu_break, prog_req, prog_erase, prog_verify, prog_refused;
  logic [1:0] prog_target;
  logic [17:0] dout;
  logic oe_any, shr;
  logic [7:0] b;
  int miscompares, n_tests, n_req;
  jtag_debug_comm_port jtag_debug_comm_port_inst (
    .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .tap_enable_fuse(tap_enable_fuse), .debug_enable_fuse(debug_enable_fuse), .tap_disable_bit(tap_disable_bit),
    .lock_bits(lock_bits), .cpu_io_sel(cpu_io_sel), .cpu_io_wr(cpu_io_wr), .cpu_io_rd(cpu_io_rd),
    .cpu_io_wdata(cpu_io_wdata), .cpu_io_rdata(cpu_io_rdata), .shared_io_wr(shared_io_wr),
    .shared_io_rd(shared_io_rd), .shared_io_rdata(shared_io_rdata), .cpu_instr_valid(cpu_instr_valid),
    .cpu_instr_ready(cpu_instr_ready), .cpu_instr(cpu_instr), .pc_valid(pc_valid), .pc(pc),
    .flow_change(flow_change), .data_valid(data_valid), .data_addr(data_addr), .cpu_break(cpu_break),
    .prog_req(prog_req), .prog_erase(prog_erase), .prog_target(prog_target), .prog_verify(prog_verify),
    .prog_data(prog_data), .prog_refused(prog_refused)
  );
  jtag_host_model jtag_host_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] rd_exp(input logic dirty, input logic [7:0] d);
    return {dirty, d[6:0]};
  endfunction
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic sc(input logic ir, input int n, input logic [17:0] d);
    jtag_host_model_inst.scan(ir, n, d, dout, oe_any);
  endtask
  // One CPU strobe; shr notes routing to the ordinary register
  task automatic cpu(input logic w, input logic [7:0] d);
    @(posedge clk);
    cpu_io_sel <= 1'b1;
    cpu_io_wr <= w;
    cpu_io_rd <= ~w;
    cpu_io_wdata <= d;
    #1 shr = shared_io_rd | shared_io_wr;
    @(posedge clk);
    cpu_io_sel <= 1'b0;
    cpu_io_wr <= 1'b0;
    cpu_io_rd <= 1'b0;
    #1;
  endtask
  // One execution cycle: program fetch or data access at a
  task automatic pcb(input logic [15:0] a, input logic dv);
    @(posedge clk);
    pc <= a;
    data_addr <= a;
    pc_valid <= ~dv;
    data_valid <= dv;
    @(posedge clk);
    {pc_valid, data_valid} <= 2'b00;
    #1;
  endtask
  always @(posedge clk) n_req += int'(prog_req === 1'b1);
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    b = 8'($urandom(73));
    {rst_n, cpu_io_sel, cpu_io_wr, cpu_io_rd, pc_valid, flow_change, data_valid} = '0;
    {tap_enable_fuse, debug_enable_fuse, tap_disable_bit, cpu_instr_ready} = 4'b1101;
    {lock_bits, cpu_io_wdata, pc, data_addr} = '0;
    shared_io_rdata = 8'($urandom);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    jtag_host_model_inst.reset_tap();
    cpu(1'b0, 8'h00);
    chk("shared_route", 1'b1, shr);
    chk("shared_rdata", shared_io_rdata, cpu_io_rdata);
    sc(1'b1, 4, OP_CTRL);
    chk("tdo_oe_on", 1'b1, oe_any);
    chk("ir_capture", 4'h1, dout[3:0]);
    sc(1'b0, 6, 6'h03);
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'hff : 8'($urandom);
      cpu(1'b1, b);
      cpu(1'b0, 8'h00);
      chk("comm_route", 1'b0, shr);
      chk("rdata_dirty", rd_exp(1'b1, b), cpu_io_rdata);
      cpu(1'b0, 8'h00);
      chk("rdata_again", rd_exp(1'b1, b), cpu_io_rdata);
      sc(1'b1, 4, OP_COMM);
      sc(1'b0, 9, 18'h0);
      chk("comm_scan", {1'b1, b}, dout[8:0]);
      cpu(1'b0, 8'h00);
      chk("rdata_clean", rd_exp(1'b0, b), cpu_io_rdata);
    end
    pcb(16'($urandom), 1'b0);
    chk("step_break", 1'b1, cpu_break);
    @(posedge clk);
    cpu_instr_ready <= 1'b0;
    b = 8'($urandom);
    sc(1'b1, 4, OP_INSTR);
    sc(1'b0, 16, {8'h95, b});
    chk("fifo_ready", 1'b1, dout[0]);
    chk("instr_valid", 1'b1, cpu_instr_valid);
    chk("instr_word", {8'h95, b}, cpu_instr);
    @(posedge clk);
    cpu_instr_ready <= 1'b1;
    @(posedge clk);
    #1 chk("instr_pop", 1'b0, cpu_instr_valid);
    sc(1'b1, 4, OP_BP);
    sc(1'b0, 18, {2'h2, 16'h1200});
    sc(1'b0, 18, {2'h3, 16'hff00});
    sc(1'b1, 4, OP_CTRL);
    sc(1'b0, 6, 6'h19);
    pcb({8'h12, b}, 1'b0);
    chk("range_pc_hit", 1'b1, cpu_break);
    pcb(16'h1300, 1'b0);
    chk("range_pc_miss", 1'b0, cpu_break);
    sc(1'b0, 6, 6'h21);
    pcb({8'h12, b}, 1'b1);
    chk("range_data_hit", 1'b1, cpu_break);
    pcb({8'h12, b}, 1'b0);
    chk("range_data_skip", 1'b0, cpu_break);
    sc(1'b0, 6, 6'h09);
    pcb(16'hff00, 1'b1);
    chk("data_slot_hit", 1'b1, cpu_break);
    pcb(16'hff00, 1'b0);
    chk("data_slot_pc", 1'b0, cpu_break);
    pcb(16'h1200, 1'b0);
    chk("pc_slot_hit", 1'b1, cpu_break);
    lock_bits <= 6'h01;
    cpu(1'b0, 8'h00);
    chk("locked_route", 1'b1, shr);
    sc(1'b1, 4, OP_COMM);
    sc(1'b0, 9, 18'h1ab);
    chk("locked_bypass", 2'b10, dout[1:0]);
    sc(1'b1, 4, OP_PROG);
    sc(1'b0, 12, 12'h480);
    chk("fuse_refused", 1'b1, prog_refused);
    sc(1'b0, 12, 12'h800);
    sc(1'b0, 12, 12'h480);
    chk("fuse_after_erase", 9'h080, {prog_refused, prog_data});
    sc(1'b0, 12, 12'h3a5);
    chk("prog_fields", 12'h3a5, {prog_erase, prog_target, prog_verify, prog_data});
    chk("prog_req_count", 18'd3, 18'(n_req));
    debug_enable_fuse <= 1'b0;
    cpu(1'b1, 8'h5a);
    chk("nofuse_route", 1'b1, shr);
    tap_disable_bit <= 1'b1;
    sc(1'b1, 4, OP_BYPASS);
    chk("tdo_oe_disabled", 1'b0, oe_any);
    {tap_disable_bit, tap_enable_fuse} <= 2'b00;
    sc(1'b1, 4, OP_BYPASS);
    chk("tdo_oe_no_fuse", 1'b0, oe_any);
    results();
  end
endmodule
`default_nettype wire
